// ==== shared/lprtc_defs.vh ====
// Constants of the low-power real-time counter: register offsets, field positions,
// reset values and widths. Assumes byte addresses on a 32-bit AXI4-Lite bus.
`ifndef LPRTC_DEFS_VH
`define LPRTC_DEFS_VH

// Register byte offsets
`define LPRTC_OFF_TASK_START 12'h000
`define LPRTC_OFF_TASK_STOP 12'h004
`define LPRTC_OFF_TASK_CLEAR 12'h008
`define LPRTC_OFF_TASK_FORCE 12'h00c
`define LPRTC_OFF_EV_TICK 12'h100
`define LPRTC_OFF_EV_WRAP 12'h104
`define LPRTC_OFF_EV_MATCH 12'h140
`define LPRTC_OFF_ROUTE 12'h340
`define LPRTC_OFF_ROUTE_SET 12'h344
`define LPRTC_OFF_ROUTE_CLR 12'h348
`define LPRTC_OFF_COUNT 12'h504
`define LPRTC_OFF_PRESCALE 12'h508
`define LPRTC_OFF_MATCH_VAL 12'h540

// Route enable field positions
`define LPRTC_RT_TICK 0
`define LPRTC_RT_WRAP 1
`define LPRTC_RT_MATCH_LSB 16

// Widths and counts
`define LPRTC_CNT_W 24
`define LPRTC_PRE_W 12
`define LPRTC_NMATCH 4

// Reset and special values
`define LPRTC_ROUTE_RST 32'h0000_0000
`define LPRTC_PRE_RST 12'h000
`define LPRTC_CNT_RST 24'h000000
`define LPRTC_CNT_MAX 24'hffffff
`define LPRTC_CNT_NEAR_WRAP 24'hfffff0

// AXI responses
`define LPRTC_RESP_OK 2'b00
`define LPRTC_RESP_DECERR 2'b11

`endif

// ==== hw/lprtc_core.v ====
// Low-power real-time counter with AXI4-Lite register slave.
// Assumes slow_clock is a level sampled on aclk, far slower than aclk;
// its edges are detected in the aclk domain, so there is a single clock.
`include "lprtc_defs.vh"

module lprtc_core (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire slow_clock,
  output reg tick_event,
  output reg wrap_event,
  output reg [3:0] match_event,
  output reg fast_clk_req,
  output reg high_freq_req,
  output reg slow_clk_req,
  output reg running
);

  // Register kinds returned by the address decoder
  localparam K_NONE = 4'd0;
  localparam K_START = 4'd1;
  localparam K_STOP = 4'd2;
  localparam K_CLEAR = 4'd3;
  localparam K_FORCE = 4'd4;
  localparam K_EV_TICK = 4'd5;
  localparam K_EV_WRAP = 4'd6;
  localparam K_EV_MATCH = 4'd7;
  localparam K_ROUTE = 4'd8;
  localparam K_ROUTE_SET = 4'd9;
  localparam K_ROUTE_CLR = 4'd10;
  localparam K_COUNT = 4'd11;
  localparam K_PRESCALE = 4'd12;
  localparam K_MATCH_VAL = 4'd13;

  // Decodes a byte address into a register kind
  function [3:0] reg_kind;
    input [11:0] a;
    begin
      case (a)
        `LPRTC_OFF_TASK_START: reg_kind = K_START;
        `LPRTC_OFF_TASK_STOP: reg_kind = K_STOP;
        `LPRTC_OFF_TASK_CLEAR: reg_kind = K_CLEAR;
        `LPRTC_OFF_TASK_FORCE: reg_kind = K_FORCE;
        `LPRTC_OFF_EV_TICK: reg_kind = K_EV_TICK;
        `LPRTC_OFF_EV_WRAP: reg_kind = K_EV_WRAP;
        `LPRTC_OFF_ROUTE: reg_kind = K_ROUTE;
        `LPRTC_OFF_ROUTE_SET: reg_kind = K_ROUTE_SET;
        `LPRTC_OFF_ROUTE_CLR: reg_kind = K_ROUTE_CLR;
        `LPRTC_OFF_COUNT: reg_kind = K_COUNT;
        `LPRTC_OFF_PRESCALE: reg_kind = K_PRESCALE;
        default: begin
          if ((a & 12'hff3) == `LPRTC_OFF_EV_MATCH)
            reg_kind = K_EV_MATCH;
          else if ((a & 12'hff3) == `LPRTC_OFF_MATCH_VAL)
            reg_kind = K_MATCH_VAL;
          else
            reg_kind = K_NONE;
        end
      endcase
    end
  endfunction

  // Register state
  reg [`LPRTC_CNT_W-1:0] count;
  reg [`LPRTC_PRE_W-1:0] prescale;
  reg [`LPRTC_PRE_W-1:0] prescale_down_latch;
  reg [31:0] event_route_enable;
  reg [`LPRTC_CNT_W-1:0] match_value [0:`LPRTC_NMATCH-1];
  reg ev_tick;
  reg ev_wrap;
  reg [3:0] ev_match;
  reg events_blocked;
  reg slow_prev;
  reg start_pend;
  reg [2:0] task_pend;
  reg [2:0] task_armed;

  // Bus write capture
  reg aw_full;
  reg w_full;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire slow_rise = slow_clock & ~slow_prev;
  wire slow_fall = ~slow_clock & slow_prev;
  wire wr_go = aw_full & w_full & ~s_axi_bvalid;
  wire [3:0] wr_kind = reg_kind(aw_addr);
  wire [1:0] wr_idx = aw_addr[3:2];
  wire wr_one = w_strb[0] & w_data[0];
  wire [3:0] rd_kind = reg_kind(s_axi_araddr);
  wire [1:0] rd_idx = s_axi_araddr[3:2];
  wire task_stop_w = wr_go & (wr_kind == K_STOP) & wr_one;
  wire apply_clear = slow_rise & task_armed[0];
  wire apply_stop = slow_rise & task_armed[1];
  wire apply_force = slow_rise & task_armed[2];
  wire apply_start = slow_rise & start_pend;
  wire inc = slow_rise & running & (prescale_down_latch == {`LPRTC_PRE_W{1'b0}})
    & ~apply_clear & ~apply_force;
  wire [`LPRTC_CNT_W-1:0] count_inc = count + {{(`LPRTC_CNT_W-1){1'b0}}, 1'b1};
  wire live = ~events_blocked & ~task_stop_w;
  wire fire_tick = inc & live & event_route_enable[`LPRTC_RT_TICK];
  wire fire_wrap = inc & live & (count == `LPRTC_CNT_MAX)
    & event_route_enable[`LPRTC_RT_WRAP];
  wire [3:0] fire_match;

  // One comparator per compare register, live only on increments
  genvar gi;
  generate
    for (gi = 0; gi < `LPRTC_NMATCH; gi = gi + 1) begin : g_match
      assign fire_match[gi] = inc & live & (count_inc == match_value[gi])
        & event_route_enable[`LPRTC_RT_MATCH_LSB + gi];
    end
  endgenerate

  // Handshake outputs
  assign s_axi_awready = ~aw_full;
  assign s_axi_wready = ~w_full;
  assign s_axi_arready = ~s_axi_rvalid;

  // Write channel capture and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPRTC_RESP_OK;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_kind == K_NONE) ? `LPRTC_RESP_DECERR : `LPRTC_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; the count is latched from the live counter on the read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LPRTC_RESP_OK;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (rd_kind == K_NONE) ? `LPRTC_RESP_DECERR : `LPRTC_RESP_OK;
      case (rd_kind)
        K_EV_TICK: s_axi_rdata <= {31'h0, ev_tick};
        K_EV_WRAP: s_axi_rdata <= {31'h0, ev_wrap};
        K_EV_MATCH: s_axi_rdata <= {31'h0, ev_match[rd_idx]};
        K_ROUTE: s_axi_rdata <= event_route_enable;
        K_ROUTE_SET: s_axi_rdata <= event_route_enable;
        K_ROUTE_CLR: s_axi_rdata <= event_route_enable;
        K_COUNT: s_axi_rdata <= {8'h00, count};
        K_PRESCALE: s_axi_rdata <= {20'h00000, prescale};
        K_MATCH_VAL: s_axi_rdata <= {8'h00, match_value[rd_idx]};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      event_route_enable <= `LPRTC_ROUTE_RST;
      prescale <= `LPRTC_PRE_RST;
      match_value[0] <= `LPRTC_CNT_RST;
      match_value[1] <= `LPRTC_CNT_RST;
      match_value[2] <= `LPRTC_CNT_RST;
      match_value[3] <= `LPRTC_CNT_RST;
    end else if (wr_go) begin
      case (wr_kind)
        K_ROUTE: event_route_enable <= w_data & 32'h000f_0003;
        K_ROUTE_SET: event_route_enable <= event_route_enable | (w_data & 32'h000f_0003);
        K_ROUTE_CLR: event_route_enable <= event_route_enable & ~w_data;
        K_PRESCALE: begin
          if (!running && !start_pend)
            prescale <= w_data[`LPRTC_PRE_W-1:0];
        end
        K_MATCH_VAL: match_value[wr_idx] <= w_data[`LPRTC_CNT_W-1:0];
        default: prescale <= prescale;
      endcase
    end
  end

  // Task hand-off: start waits for a rising edge, the rest for a fall then a rise
  always @(posedge aclk) begin
    if (!aresetn) begin
      slow_prev <= 1'b0;
      start_pend <= 1'b0;
      task_pend <= 3'b000;
      task_armed <= 3'b000;
      events_blocked <= 1'b1;
    end else begin
      slow_prev <= slow_clock;
      start_pend <= (start_pend & ~slow_rise)
        | (wr_go & (wr_kind == K_START) & wr_one);
      task_pend <= (task_pend & ~(slow_rise ? task_armed : 3'b000))
        | {wr_go & (wr_kind == K_FORCE) & wr_one, task_stop_w,
           wr_go & (wr_kind == K_CLEAR) & wr_one};
      if (slow_fall)
        task_armed <= task_pend;
      else if (slow_rise)
        task_armed <= 3'b000;
      if (task_stop_w)
        events_blocked <= 1'b1;
      else if (apply_start)
        events_blocked <= 1'b0;
    end
  end

  // Slow-edge counter and prescaler
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= `LPRTC_CNT_RST;
      prescale_down_latch <= `LPRTC_PRE_RST;
      running <= 1'b0;
    end else begin
      if (apply_clear) begin
        count <= `LPRTC_CNT_RST;
        prescale_down_latch <= prescale;
      end else if (apply_force) begin
        count <= `LPRTC_CNT_NEAR_WRAP;
        prescale_down_latch <= prescale;
      end else if (apply_start) begin
        prescale_down_latch <= prescale;
      end else if (inc) begin
        count <= count_inc;
        prescale_down_latch <= prescale;
      end else if (slow_rise && running) begin
        prescale_down_latch <= prescale_down_latch - {{(`LPRTC_PRE_W-1){1'b0}}, 1'b1};
      end
      if (apply_stop)
        running <= 1'b0;
      else if (apply_start)
        running <= 1'b1;
    end
  end

  // Event flags: hardware set wins over a software clear of zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      ev_tick <= 1'b0;
      ev_wrap <= 1'b0;
      ev_match <= 4'h0;
    end else begin
      ev_tick <= fire_tick
        | (ev_tick & ~(wr_go & (wr_kind == K_EV_TICK) & ~w_data[0]));
      ev_wrap <= fire_wrap
        | (ev_wrap & ~(wr_go & (wr_kind == K_EV_WRAP) & ~w_data[0]));
      ev_match <= fire_match | (ev_match & ~(
        {4{wr_go & (wr_kind == K_EV_MATCH) & ~w_data[0]}} & (4'h1 << wr_idx)));
    end
  end

  // Event pulses and clock requests; unrouted events never reach here
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_event <= 1'b0;
      wrap_event <= 1'b0;
      match_event <= 4'h0;
      fast_clk_req <= 1'b0;
      high_freq_req <= 1'b0;
      slow_clk_req <= 1'b0;
    end else begin
      tick_event <= fire_tick;
      wrap_event <= fire_wrap;
      match_event <= fire_match;
      fast_clk_req <= fire_tick | fire_wrap | (|fire_match);
      high_freq_req <= fire_tick | fire_wrap | (|fire_match);
      slow_clk_req <= (running & ~apply_stop) | start_pend;
    end
  end

endmodule // lprtc_core

// ==== dv/lprtc_core_checker.sv ====
// Port checker for lprtc_core: read answers, event pulses and clock requests.
// Assumes it is bound to lprtc_core, one clock aclk, synchronous reset aresetn.
module lprtc_core_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tick_event,
  input wire logic wrap_event,
  input wire logic [3:0] match_event,
  input wire logic fast_clk_req,
  input wire logic high_freq_req,
  input wire logic slow_clk_req,
  input wire logic running
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Any event fired in this cycle
  wire any_ev = tick_event | wrap_event | (|match_event);
  // Read address accepted
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Read answer waiting for the master
  sequence r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  reset_quiet_a: assert property ($rose(aresetn) |-> !any_ev && !s_axi_rvalid)
    else $error("event or answer right after reset");
  event_clk_req_a: assert property (any_ev |-> fast_clk_req && high_freq_req)
    else $error("event without clock request");
  clk_req_cause_a: assert property (fast_clk_req |-> any_ev)
    else $error("clock request without routed event");
  tick_pulse_a: assert property (tick_event |=> !tick_event)
    else $error("tick longer than one cycle");
  wrap_pulse_a: assert property (wrap_event |=> !wrap_event)
    else $error("wrap longer than one cycle");
  read_latency_a: assert property (ar_taken |-> ##[1:6] s_axi_rvalid)
    else $error("count read slower than six cycles");
  rdata_hold_a: assert property (r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  arready_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken while answering");
  slow_req_a: assert property (running |-> slow_clk_req)
    else $error("running without slow clock request");
endmodule // lprtc_core_checker

bind lprtc_core lprtc_core_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tick_event(tick_event),
  .wrap_event(wrap_event), .match_event(match_event), .fast_clk_req(fast_clk_req),
  .high_freq_req(high_freq_req), .slow_clk_req(slow_clk_req), .running(running));

// ==== dv/lprtc_slow_src.sv ====
// Slow clock source model behind the slow_clock input.
// Assumes aclk paces it; the half period is shortened to HALF aclk cycles.
module lprtc_slow_src #(parameter int HALF = 10) (
  input wire logic aclk,
  input wire logic slow_clk_req,
  output logic slow_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial slow_clock = 1'h0;
  // Oscillator runs only while requested, else stands still
  always @(posedge aclk) begin
    if (slow_clk_req) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) slow_clock <= ~slow_clock;
    end
  end
endmodule // lprtc_slow_src

// ==== dv/lprtc_core_tb_top.sv ====
// Testbench for lprtc_core: register tests over AXI4-Lite.
// Assumes the slow clock model runs at 20 aclk cycles a period.
module lprtc_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, v;
  logic [1:0] bresp, rresp, r;
  logic [3:0] match_event;
  logic awready, wready, bvalid, arready, rvalid, slow_clock, tick_event, wrap_event;
  logic fast_clk_req, high_freq_req, slow_clk_req, running;
  int cnt [7];
  int cyc, fails, n_compared;
  always #20 aclk = ~aclk;
  lprtc_core i_lprtc_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .slow_clock(slow_clock),
    .tick_event(tick_event), .wrap_event(wrap_event), .match_event(match_event),
    .fast_clk_req(fast_clk_req), .high_freq_req(high_freq_req), .slow_clk_req(slow_clk_req),
    .running(running));
  lprtc_slow_src i_lprtc_slow_src (.aclk(aclk), .slow_clk_req(slow_clk_req),
    .slow_clock(slow_clock));
  // Event counters and run timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tick_event) cnt[0] <= cnt[0] + 1;
    if (wrap_event) cnt[1] <= cnt[1] + 1;
    for (int i = 0; i < 4; i++)
      if (match_event[i]) cnt[2 + i] <= cnt[2 + i] + 1;
    if (fast_clk_req) cnt[6] <= cnt[6] + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] x);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tb);
    bready <= 1'h0;
    // Let one edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, tv;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end while (!tv);
    rready <= 1'h0;
    // Let one edge pass so a following call never re-raises rready in this step
    @(posedge aclk);
  endtask
  task automatic wait_ev(input int k, input int lim);
    int c0;
    c0 = cnt[k];
    repeat (lim) if (cnt[k] == c0) @(posedge aclk);
    chk("event seen", 1, cnt[k] != c0);
  endtask
  task automatic quiet(input int k, input int n);
    int c0;
    c0 = cnt[k];
    repeat (n) @(posedge aclk);
    chk("no event", c0, cnt[k]);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence of register tests
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(12'h340);
    chk("route", 0, d);
    rd(12'h508);
    chk("prescale", 0, d);
    rd(12'h504);
    chk("count", 0, d);
    rd(12'h800);
    chk("unmapped resp", 3, r);
    $display("test reset done");
    wr(12'h344, 32'h000f0003);
    wr(12'h540, 5);
    wr(12'h000, 1);
    wait_ev(0, 100);
    rd(12'h504);
    chk("first count", 1, d);
    wait_ev(2, 200);
    rd(12'h504);
    chk("match count", 5, d);
    rd(12'h504);
    wr(12'h544, d + 3); // stays clear of count plus one
    wait_ev(3, 200);
    $display("test start and match done");
    wr(12'h004, 1);
    quiet(0, 100);
    rd(12'h504);
    v = d;
    repeat (60) @(posedge aclk);
    rd(12'h504);
    chk("count held", v, d);
    wr(12'h548, d);
    wr(12'h508, 2);
    rd(12'h508);
    chk("prescale", 2, d);
    wr(12'h000, 1);
    quiet(4, 200);
    wait_ev(0, 300);
    v = cyc;
    wait_ev(0, 300);
    chk("tick spacing", 60, cyc - v);
    wr(12'h508, 5);
    rd(12'h508);
    chk("prescale kept", 2, d);
    $display("test stop and prescale done");
    wr(12'h00c, 1);
    wait_ev(1, 1500);
    rd(12'h504);
    chk("count wrapped", 0, d);
    wr(12'h540, 0);
    wr(12'h008, 1);
    quiet(2, 150);
    rd(12'h504);
    chk("count cleared", 1, d < 4);
    wr(12'h348, 32'h000f0003);
    quiet(6, 200);
    rd(12'h340);
    chk("route off", 0, d);
    $display("test wrap clear route done");
    tally_and_finish;
  end
endmodule // lprtc_core_tb_top
